// >>> rtl/estc_defines.svh
`ifndef ESTC_DEFINES_SVH
`define ESTC_DEFINES_SVH

// register byte addresses
`define ESTC_ADDR_CTRL 8'h00
`define ESTC_ADDR_CMD 8'h04
`define ESTC_ADDR_USER 8'h08
`define ESTC_ADDR_EXPO 8'h0c
`define ESTC_ADDR_PERIOD 8'h10
`define ESTC_ADDR_MINPER 8'h14
`define ESTC_ADDR_TMRDUR 8'h18
`define ESTC_ADDR_STATUS 8'h1c

// control field positions
`define ESTC_CTRL_TRIGON 0
`define ESTC_CTRL_SRC_LSB 1
`define ESTC_CTRL_SRC_MSB 3
`define ESTC_CTRL_RISING 4
`define ESTC_CTRL_PW 5
`define ESTC_CTRL_TMRLVL 6

// command bits, write-one pulses
`define ESTC_CMD_START 0
`define ESTC_CMD_STOP 1
`define ESTC_CMD_SWTRIG 2

// reset values, times in clk_sys cycles
`define ESTC_RST_CTRL 32'h0000_0010
`define ESTC_RST_EXPO 32'h0000_0100
`define ESTC_RST_PERIOD 32'h0000_1000
`define ESTC_RST_MINPER 32'h0000_0800
`define ESTC_RST_TMRDUR 32'h0000_0100

`define ESTC_RESP_OKAY 2'b00
`define ESTC_RESP_SLVERR 2'b10

`endif

// >>> rtl/estc_pkg.sv
package estc_pkg;

   typedef logic [31:0] estc_word_t;
   typedef logic [7:0] estc_addr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_EXPOSE = 3'h4
   } estc_state_e;

   typedef enum logic [2:0] {
      SRC_SW = 3'h0,
      SRC_USER = 3'h1,
      SRC_LINK = 3'h2,
      SRC_TIMER = 3'h3,
      SRC_LINE = 3'h4
   } estc_src_e;

endpackage

// >>> rtl/estc_tick_if.sv
`timescale 1ns/1ns
interface estc_tick_if;
   import estc_pkg::*;
   logic run;
   estc_word_t period;
   logic tick;
   modport ctl (output run, output period, input tick);
   modport tmr (input run, input period, output tick);
endinterface

// >>> rtl/estc_line_sync.sv
`timescale 1ns/1ns
module estc_line_sync
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic lineIn,
   output logic lineOut
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic stable_reg;

   // s1 feeds only s2; a change counts once s2 and s3 agree
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         stable_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= lineIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            stable_reg <= s3_reg; // R21
      end
   end

   assign lineOut = stable_reg;
endmodule

// >>> rtl/estc_period_timer.sv
`timescale 1ns/1ns
module estc_period_timer
(
   input wire logic clk_sys,
   input wire logic nrst,
   estc_tick_if.tmr tk
);
   import estc_pkg::*;

   estc_word_t cnt_reg;
   logic tick_reg;

   // idle counter sits at zero so the first event follows start at once
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_reg <= 32'h0000_0000;
         tick_reg <= 1'b0;
      end
      else if (!tk.run)
      begin
         cnt_reg <= 32'h0000_0000;
         tick_reg <= 1'b0;
      end
      else if (cnt_reg == 32'h0000_0000)
      begin
         cnt_reg <= tk.period - 32'h0000_0001; // R22
         tick_reg <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg - 32'h0000_0001;
         tick_reg <= 1'b0;
      end
   end

   assign tk.tick = tick_reg;

   a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!nrst)
      tick_reg && tk.run && tk.period > 32'h0000_0001 |=> !tick_reg) // R22
      else $error("period tick repeated too soon");
endmodule

// >>> rtl/estc_top.sv
// Operation
// R1 - trigger mode off: all exposure starts are made internally
// R2 - free-run starts follow acquisition start and stop at acquisition stop
// R3 - free-run rate is programmed rate, limited to maximum allowed rate
// R4 - trigger mode off: exposure lasts the programmed exposure duration
// R5 - trigger mode on: frame begins only on the selected source's start event
// R6 - edge polarity chooses rising or falling transition as start event
// R7 - software source: exposure always uses programmed duration
// R8 - link or line source: timed duration, or incoming pulse in pulse-width mode
// R9 - timer source pulse-width: timer duration if edge, signal level if level
// R10 - user output source pulse-width: exposure spans user output on to off
// R11 - software source while waiting: software trigger starts exposure
// R12 - leave waiting on exposure start, return when ready again
// R13 - software triggers arriving while not ready are dropped, never queued
// R14 - trigger issuer keeps rate at or below maximum allowed frame rate
// R15 - link or line: each selected edge while waiting starts acquisition
// R16 - link trigger: one frame per accepted trigger period
// R17 - line source uses external control input as start source
// R18 - link source uses host link trigger events as start source
// R19 - pulse-width: exposure from selected edge to the opposite edge
// R20 - timed mode: start events during an exposure are ignored
// R21 - synchronise pin triggers, one single-cycle pulse per qualifying edge
// R22 - free-run interval counter loads larger of period and minimum period
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "estc_defines.svh"
module estc_top
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire estc_pkg::estc_addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire estc_pkg::estc_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire estc_pkg::estc_addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output estc_pkg::estc_word_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic externalLine,
   input wire logic hostLinkTrigger,
   input wire logic timerActive,
   output logic exposureActive,
   output logic frameStart,
   output logic waitingForStart
);
   import estc_pkg::*;

   function automatic logic addrMapped(input estc_addr_t a);
      addrMapped = (a[1:0] == 2'b00) && (a <= `ESTC_ADDR_STATUS);
   endfunction

   function automatic estc_word_t applyStrb(input estc_word_t old, input estc_word_t nw, input logic [3:0] st);
      integer i;
      applyStrb = old;
      for (i = 0; i < 4; i = i + 1)
         if (st[i])
            applyStrb[i*8 +: 8] = nw[i*8 +: 8];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave

   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   estc_word_t rdata_reg;
   estc_addr_t awAddr_reg;
   estc_word_t wData_reg;
   logic [3:0] wStrb_reg;
   logic doWrite;

   assign doWrite = !awready_reg && !wready_reg && !bvalid_reg;

   // address and data are taken in either order, the write happens once both are held
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= `ESTC_RESP_OKAY;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0000_0000;
         wStrb_reg <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && awready_reg)
         begin
            awAddr_reg <= s_axi_awaddr;
            awready_reg <= 1'b0;
         end
         if (s_axi_wvalid && wready_reg)
         begin
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
            wready_reg <= 1'b0;
         end
         if (doWrite)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addrMapped(awAddr_reg) ? `ESTC_RESP_OKAY : `ESTC_RESP_SLVERR;
         end
         else if (bvalid_reg && s_axi_bready)
         begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers

   estc_word_t ctrl_reg;
   estc_word_t expo_reg;
   estc_word_t period_reg;
   estc_word_t minPer_reg;
   estc_word_t tmrDur_reg;
   logic userOut_reg;
   logic acqStart_reg;
   logic acqStop_reg;
   logic swTrig_reg;
   logic acquiring_reg;
   estc_state_e state_reg;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_reg <= `ESTC_RST_CTRL;
         expo_reg <= `ESTC_RST_EXPO;
         period_reg <= `ESTC_RST_PERIOD;
         minPer_reg <= `ESTC_RST_MINPER;
         tmrDur_reg <= `ESTC_RST_TMRDUR;
         userOut_reg <= 1'b0;
      end
      else if (doWrite)
      begin
         case (awAddr_reg)
            `ESTC_ADDR_CTRL: ctrl_reg <= applyStrb(ctrl_reg, wData_reg, wStrb_reg);
            `ESTC_ADDR_EXPO: expo_reg <= applyStrb(expo_reg, wData_reg, wStrb_reg);
            `ESTC_ADDR_PERIOD: period_reg <= applyStrb(period_reg, wData_reg, wStrb_reg);
            `ESTC_ADDR_MINPER: minPer_reg <= applyStrb(minPer_reg, wData_reg, wStrb_reg);
            `ESTC_ADDR_TMRDUR: tmrDur_reg <= applyStrb(tmrDur_reg, wData_reg, wStrb_reg);
            `ESTC_ADDR_USER:
               if (wStrb_reg[0])
                  userOut_reg <= wData_reg[0];
            default: ;
         endcase
      end
   end

   // command bits live one cycle; nothing is stored, so a late trigger is lost
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         acqStart_reg <= 1'b0;
         acqStop_reg <= 1'b0;
         swTrig_reg <= 1'b0;
      end
      else
      begin
         acqStart_reg <= doWrite && awAddr_reg == `ESTC_ADDR_CMD && wStrb_reg[0] && wData_reg[`ESTC_CMD_START];
         acqStop_reg <= doWrite && awAddr_reg == `ESTC_ADDR_CMD && wStrb_reg[0] && wData_reg[`ESTC_CMD_STOP];
         swTrig_reg <= doWrite && awAddr_reg == `ESTC_ADDR_CMD && wStrb_reg[0] && wData_reg[`ESTC_CMD_SWTRIG]; // R13
      end
   end

   // read side; status shows acquisition and state bits
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= `ESTC_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && arready_reg)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= addrMapped(s_axi_araddr) ? `ESTC_RESP_OKAY : `ESTC_RESP_SLVERR;
         case (s_axi_araddr)
            `ESTC_ADDR_CTRL: rdata_reg <= {25'h0, ctrl_reg[6:0]};
            `ESTC_ADDR_USER: rdata_reg <= {31'h0, userOut_reg};
            `ESTC_ADDR_EXPO: rdata_reg <= expo_reg;
            `ESTC_ADDR_PERIOD: rdata_reg <= period_reg;
            `ESTC_ADDR_MINPER: rdata_reg <= minPer_reg;
            `ESTC_ADDR_TMRDUR: rdata_reg <= tmrDur_reg;
            `ESTC_ADDR_STATUS: rdata_reg <= {28'h0000000, state_reg, acquiring_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger sources

   logic trigOn;
   logic rising;
   logic pwMode;
   logic tmrLevel;
   estc_src_e src;
   logic lineSync;
   logic linkSync;
   logic srcLevel;
   logic srcPrev_reg;
   logic startEdge;
   logic endEdge;
   logic startEvt;
   logic follow;
   estc_word_t expLoad;
   estc_tick_if tk ();

   assign trigOn = ctrl_reg[`ESTC_CTRL_TRIGON];
   assign rising = ctrl_reg[`ESTC_CTRL_RISING];
   assign pwMode = ctrl_reg[`ESTC_CTRL_PW];
   assign tmrLevel = ctrl_reg[`ESTC_CTRL_TMRLVL];
   assign src = estc_src_e'(ctrl_reg[`ESTC_CTRL_SRC_MSB:`ESTC_CTRL_SRC_LSB]);

   estc_line_sync u_line_sync (.clk_sys(clk_sys), .nrst(nrst), .lineIn(externalLine), .lineOut(lineSync)); // R17
   estc_line_sync u_link_sync (.clk_sys(clk_sys), .nrst(nrst), .lineIn(hostLinkTrigger), .lineOut(linkSync)); // R18

   // undefined source codes give a dead source, so trigger mode on then never starts
   always_comb
   begin
      case (src)
         SRC_USER: srcLevel = userOut_reg;
         SRC_LINK: srcLevel = linkSync; // R18
         SRC_TIMER: srcLevel = timerActive;
         SRC_LINE: srcLevel = lineSync; // R17
         default: srcLevel = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         srcPrev_reg <= 1'b0;
      else
         srcPrev_reg <= srcLevel;
   end

   assign startEdge = rising ? (srcLevel && !srcPrev_reg) : (!srcLevel && srcPrev_reg); // R6 R21
   assign endEdge = rising ? (!srcLevel && srcPrev_reg) : (srcLevel && !srcPrev_reg); // R19

   // a software start is the command pulse, otherwise the chosen edge, or the free-run tick
   assign startEvt = trigOn ? ((src == SRC_SW) ? swTrig_reg : startEdge) : tk.tick; // R1 R5 R11 R15

   // software never follows a pulse; in pulse-width mode an edge-started timer uses its own duration
   assign follow = trigOn && pwMode && src != SRC_SW && !(src == SRC_TIMER && !tmrLevel); // R7 R8 R9 R10 R19
   assign expLoad = (trigOn && pwMode && src == SRC_TIMER && !tmrLevel) ? tmrDur_reg : expo_reg; // R4 R9

   // free-run limit: programmed period, never shorter than the minimum period
   assign tk.run = acquiring_reg && !trigOn; // R2
   assign tk.period = (period_reg > minPer_reg) ? period_reg : minPer_reg; // R3 R22

   estc_period_timer u_timer (.clk_sys(clk_sys), .nrst(nrst), .tk(tk));

   ////////////////////////////////////////////////////////////////////////////
   // acquisition state

   estc_word_t expCnt_reg;
   logic followHeld_reg;
   logic frameStart_reg;
   logic expDone;

   // a stop lets the running exposure finish before going idle
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         acquiring_reg <= 1'b0;
      else if (acqStart_reg)
         acquiring_reg <= 1'b1; // R2
      else if (acqStop_reg)
         acquiring_reg <= 1'b0; // R2
   end

   assign expDone = followHeld_reg ? endEdge : (expCnt_reg == 32'h0000_0000); // R4 R19

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         state_reg <= ST_IDLE;
      else
      begin
         unique case (state_reg)
            ST_IDLE:
               if (acquiring_reg)
                  state_reg <= ST_WAIT;
            ST_WAIT:
               if (!acquiring_reg)
                  state_reg <= ST_IDLE;
               else if (startEvt)
                  state_reg <= ST_EXPOSE; // R12 R16
            ST_EXPOSE:
               if (expDone)
                  state_reg <= acquiring_reg ? ST_WAIT : ST_IDLE; // R12 R20
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // length is fixed at start; a zero duration still exposes one cycle
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         expCnt_reg <= 32'h0000_0000;
         followHeld_reg <= 1'b0;
         frameStart_reg <= 1'b0;
      end
      else
      begin
         frameStart_reg <= state_reg == ST_WAIT && acquiring_reg && startEvt;
         if (state_reg == ST_WAIT && acquiring_reg && startEvt)
         begin
            expCnt_reg <= (expLoad == 32'h0000_0000) ? expLoad : expLoad - 32'h0000_0001; // R4 R7 R8
            followHeld_reg <= follow; // R8 R9 R10
         end
         else if (state_reg == ST_EXPOSE && expCnt_reg != 32'h0000_0000)
            expCnt_reg <= expCnt_reg - 32'h0000_0001;
      end
   end

   assign exposureActive = state_reg[2];
   assign waitingForStart = state_reg[1];
   assign frameStart = frameStart_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   estc_word_t hlpLen_reg;
   estc_word_t hlpTarget_reg;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         hlpLen_reg <= 32'h0000_0000;
         hlpTarget_reg <= 32'h0000_0000;
      end
      else if (state_reg == ST_WAIT && acquiring_reg && startEvt)
      begin
         hlpLen_reg <= 32'h0000_0000;
         hlpTarget_reg <= (expLoad == 32'h0000_0000) ? 32'h0000_0001 : expLoad;
      end
      else if (state_reg == ST_EXPOSE)
         hlpLen_reg <= hlpLen_reg + 32'h0000_0001;
   end

   sequence swLate;
      trigOn && src == SRC_SW && swTrig_reg && state_reg != ST_WAIT;
   endsequence

   sequence waitThenEdge;
      state_reg == ST_WAIT && acquiring_reg ##0 trigOn && src != SRC_SW && startEdge;
   endsequence

   a_freerun_internal: assert property (@(posedge clk_sys) disable iff (!nrst) // R1
      state_reg == ST_WAIT && acquiring_reg && !trigOn && tk.tick |=> state_reg == ST_EXPOSE && frameStart)
      else $error("free-run tick did not start exposure");
   a_acq_start: assert property (@(posedge clk_sys) disable iff (!nrst) // R2
      state_reg == ST_IDLE && acqStart_reg |=> ##1 state_reg == ST_WAIT)
      else $error("acquisition start did not reach waiting");
   a_timed_length: assert property (@(posedge clk_sys) disable iff (!nrst) // R4
      state_reg == ST_EXPOSE && !followHeld_reg && expDone |-> hlpLen_reg + 32'h0000_0001 == hlpTarget_reg)
      else $error("timed exposure length differs from setting");
   a_trig_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // R5
      state_reg == ST_WAIT && trigOn && !startEvt |=> state_reg != ST_EXPOSE)
      else $error("exposure began without start event");
   a_edge_start: assert property (@(posedge clk_sys) disable iff (!nrst) // R15
      waitThenEdge |=> state_reg == ST_EXPOSE ##0 $rose(exposureActive))
      else $error("selected edge did not start exposure");
   a_sw_start: assert property (@(posedge clk_sys) disable iff (!nrst) // R11
      state_reg == ST_WAIT && acquiring_reg && trigOn && src == SRC_SW && swTrig_reg |=> frameStart)
      else $error("software trigger ignored while waiting");
   a_sw_drop: assert property (@(posedge clk_sys) disable iff (!nrst) // R13
      swLate ##1 (!swTrig_reg && trigOn && src == SRC_SW) |=> !frameStart)
      else $error("late software trigger was queued");
   a_pw_end: assert property (@(posedge clk_sys) disable iff (!nrst) // R19
      state_reg == ST_EXPOSE && followHeld_reg && endEdge |=> !exposureActive)
      else $error("pulse-width exposure missed its end edge");
   a_ignore_overlap: assert property (@(posedge clk_sys) disable iff (!nrst) // R20
      state_reg == ST_EXPOSE && !followHeld_reg && expCnt_reg > 32'h0000_0001 |=> exposureActive [*2])
      else $error("timed exposure cut short");
   a_single_pulse: assert property (@(posedge clk_sys) disable iff (!nrst) // R21
      frameStart |=> !frameStart)
      else $error("start pulse longer than one cycle");
endmodule

// >>> testbench/estc_trig_src.sv
`timescale 1ns/1ns
module estc_trig_src
(
   input wire logic clk_sys,
   output logic lineOut,
   output logic linkOut,
   output logic tmrOut
);
   initial
   begin
      lineOut = 1'b0;
      linkOut = 1'b0;
      tmrOut = 1'b0;
   end
   //////////////////////////////////////////////////
   // levels change just after the edge, as the source's own flops would
   task automatic drive(input int sel, input logic v);
      @(posedge clk_sys);
      case (sel)
         2: linkOut <= v;
         3: tmrOut <= v;
         default: lineOut <= v;
      endcase
   endtask
   // one edge pair per pulse; the caller owns the spacing between pulses
   task automatic pulse(input int sel, input logic act, input int w);
      drive(sel, act);
      repeat (w - 1) @(posedge clk_sys);
      drive(sel, !act);
   endtask
endmodule

// >>> testbench/test_exposure_start_trigger_control.sv
`timescale 1ns/1ns
`include "estc_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_exposure_start_trigger_control;
   import estc_pkg::*;
   estc_addr_t awaddr, araddr;
   estc_word_t wdata, rdata, rv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rs;
   logic clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic extLine, linkTrig, tmrAct, expActive, frameStart, waiting;
   int n_errors = 0, tests_run = 0, cyc = 0, nFs = 0;

   estc_top dut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .externalLine(extLine),
      .hostLinkTrigger(linkTrig), .timerActive(tmrAct), .exposureActive(expActive),
      .frameStart(frameStart), .waitingForStart(waiting));
   estc_trig_src src (.clk_sys(clk_sys), .lineOut(extLine), .linkOut(linkTrig), .tmrOut(tmrAct));
   //////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // whole run is a few thousand cycles; the ceiling only catches a lost handshake
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (frameStart)
         nFs <= nFs + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         end_of_test();
      end
   end
   //////////////////////////////////////////////////
   task automatic end_of_test();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input estc_addr_t a, input estc_word_t d, output logic [1:0] r);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge clk_sys);
         if (awvalid && awready)
         begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge clk_sys);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic put(input estc_addr_t a, input estc_word_t d);
      wr(a, d, rs);
   endtask
   task automatic rd(input estc_addr_t a, output estc_word_t d, output logic [1:0] r);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // stop first so a new setting never sees a half-configured source
   task automatic arm(input estc_word_t c);
      int t;
      t = 0;
      put(`ESTC_ADDR_CMD, 32'h2);
      put(`ESTC_ADDR_CTRL, c);
      put(`ESTC_ADDR_CMD, 32'h1);
      while (!waiting && t < 100)
      begin
         @(posedge clk_sys);
         t++;
      end
   endtask
   task automatic meas(output int w, output int st);
      int t;
      t = 0;
      w = 0;
      do
      begin
         @(posedge clk_sys);
         t++;
      end while (!frameStart && t < 3000);
      st = $time / 8;
      while (expActive && w < 3000)
      begin
         w++;
         @(posedge clk_sys);
      end
   endtask
   //////////////////////////////////////////////////
   task automatic t_regs();
      estc_word_t e[8];
      e = '{`ESTC_RST_CTRL, 32'h0, 32'h0, `ESTC_RST_EXPO, `ESTC_RST_PERIOD, `ESTC_RST_MINPER, `ESTC_RST_TMRDUR, 32'h2};
      for (int i = 0; i < 8; i++)
      begin
         rd(8'(i * 4), rv, rs);
         `CHK("reset value", e[i], rv)
         `CHK("read resp", `ESTC_RESP_OKAY, rs)
      end
      rd(8'h20, rv, rs);
      `CHK("unmapped read", `ESTC_RESP_SLVERR, rs)
      wr(8'h22, 32'h1, rs);
      `CHK("unmapped write", `ESTC_RESP_SLVERR, rs)
      put(`ESTC_ADDR_STATUS, 32'hff);
      rd(`ESTC_ADDR_STATUS, rv, rs);
      `CHK("status read-only", 32'h2, rv)
   endtask
   task automatic t_free();
      int w, s1, s2, n;
      int per[2] = '{20, 60};
      put(`ESTC_ADDR_EXPO, 32'h5);
      put(`ESTC_ADDR_MINPER, 32'd40);
      for (int i = 0; i < 2; i++)
      begin
         put(`ESTC_ADDR_PERIOD, 32'(per[i]));
         arm(32'h10);
         meas(w, s1);
         meas(w, s2);
         `CHK("free-run exposure", 5, w)
         `CHK("free-run interval", (per[i] > 40) ? per[i] : 40, s2 - s1)
      end
      put(`ESTC_ADDR_CMD, 32'h2);
      repeat (20) @(posedge clk_sys);
      n = nFs;
      repeat (200) @(posedge clk_sys);
      `CHK("frames after stop", n, nFs)
      `CHK("idle after stop", 1'b0, waiting)
   endtask
   task automatic t_soft();
      int w, s, n;
      put(`ESTC_ADDR_EXPO, 32'd30);
      arm(32'h31);
      `CHK("waiting", 1'b1, waiting)
      n = nFs;
      repeat (100) @(posedge clk_sys);
      `CHK("no start untriggered", n, nFs)
      fork
         put(`ESTC_ADDR_CMD, 32'h4);
         meas(w, s);
      join
      `CHK("software exposure", 30, w)
      n = nFs;
      put(`ESTC_ADDR_CMD, 32'h4);
      put(`ESTC_ADDR_CMD, 32'h4);
      repeat (100) @(posedge clk_sys);
      `CHK("busy trigger dropped", n + 1, nFs)
      `CHK("waiting again", 1'b1, waiting)
   endtask
   task automatic t_pin();
      int w, s, n, sel;
      logic act;
      put(`ESTC_ADDR_EXPO, 32'd30);
      for (int k = 0; k < 4; k++)
      begin
         sel = (k < 2) ? SRC_LINK : SRC_LINE;
         act = (k % 2 == 0);
         put(`ESTC_ADDR_CMD, 32'h2);
         src.drive(sel, !act);
         arm(32'(1 | (sel << 1) | (act << 4)));
         n = nFs;
         src.pulse(sel, act, 10);
         repeat (5) @(posedge clk_sys);
         src.pulse(sel, act, 10);
         repeat (60) @(posedge clk_sys);
         src.pulse(sel, act, 10);
         repeat (60) @(posedge clk_sys);
         `CHK("frames per edge", n + 2, nFs)
         arm(32'(1 | (sel << 1) | (act << 4) | 32'h20));
         fork
            src.pulse(sel, act, 40);
            meas(w, s);
         join
         `CHK("pulse-width exposure", 1'b1, w >= 40 && w <= 41)
      end
   endtask
   task automatic t_timer();
      int w, s;
      put(`ESTC_ADDR_TMRDUR, 32'd25);
      arm(32'h37);
      fork
         src.pulse(3, 1'b1, 5);
         meas(w, s);
      join
      `CHK("timer edge exposure", 25, w)
      arm(32'h77);
      fork
         src.pulse(3, 1'b1, 40);
         meas(w, s);
      join
      `CHK("timer level exposure", 1'b1, w >= 40 && w <= 41)
   endtask
   task automatic t_user();
      int w, s, t1, t2;
      arm(32'h33);
      fork
         begin
            put(`ESTC_ADDR_USER, 32'h1);
            t1 = $time / 8;
            repeat (50) @(posedge clk_sys);
            put(`ESTC_ADDR_USER, 32'h0);
            t2 = $time / 8;
         end
         meas(w, s);
      join
      `CHK("user output exposure", 1'b1, w >= t2 - t1 - 1 && w <= t2 - t1 + 1)
   endtask
   //////////////////////////////////////////////////
   initial
   begin
      nrst = 1'b0;
      awaddr = '0;
      awvalid = 1'b0;
      wdata = '0;
      wstrb = 4'hf;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = '0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      t_regs();
      t_free();
      t_soft();
      t_pin();
      t_timer();
      t_user();
      end_of_test();
   end
endmodule
